// file: dv/smcp_policy_tb.sv
/*
 Self-checking bench of smcp_policy: AXI4-Lite master tasks, reference
 model of the verdict, scenarios. Assumes smcp_pkg and the reader model.
*/
`timescale 1ns/10ps
module smcp_policy_tb;
   import smcp_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v, seed;
   logic [3:0] wstrb, pw_locked, au_locked;
   logic [1:0] bresp, rresp, rs;
   smcp_cmd_t cmd, c;
   smcp_verd_t verd;
   smcp_att_t att;
   smcp_txn_t txn;
   logic [7:0] ar [4];
   logic [7:0] pick [8] = '{8'h0E, 8'h0F, 8'h0D, 8'h18, 8'h22, 8'h23, 8'hC0, 8'hFF};
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;

   smcp_policy #(.AT8_MAX_CYC(40), .W16_MAX_CYC(30), .R64_MAX_CYC(35)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .cmd(cmd), .verd(verd), .att(att), .pw_locked(pw_locked), .au_locked(au_locked),
      .txn(txn), .irq(irq));
   smcp_reader_model rdr_u (.aclk(aclk), .cmd(cmd), .att(att), .txn(txn));

   initial begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // reference verdict, checks taken in priority order
   function logic [12:0] exp_v(input smcp_cmd_t k);
      logic [7:0] st;
      logic w;
      logic [1:0] md;
      w = (k.op == OP_USR_WR) || (k.op == OP_SYS_WR);
      md = ar[k.zone][3:2];
      if (k.op == OP_SYS_WR && k.anti_tear) st = 8'hB1;
      else if (k.op == OP_SYS_WR && k.addr >= 8'hC0) st = 8'hB2;
      else if (k.op == OP_SYS_WR && k.addr[7:1] == 7'h07) st = 8'hB3;
      else if (k.op == OP_SYS_RD && k.addr >= 8'hC0) st = 8'hB2;
      else if (w && (k.auth_on || k.enc_on) && !k.cksum_ok) st = 8'hB4;
      else if (k.op == OP_USR_WR && ((md == 2'h1 && !(k.auth_on || k.enc_on))
               || (md[1] && !k.enc_on))) st = 8'hB5;
      else st = 8'h00;
      return {1'b1, st == 8'h00, st, w && st == 8'h00,
              k.op == OP_USR_WR && ar[k.zone][0] && k.zone == 2'h1,
              k.op == OP_SYS_WR && (k.addr <= 8'h0D || (k.addr >= 8'h18 && k.addr <= 8'h22))};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask
   task wr(input logic [5:0] ix, input logic [31:0] d, input logic [3:0] sb,
           output logic [1:0] r);
      logic a_ok, w_ok;
      a_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      awaddr <= {ix, 2'b00};
      wdata <= d;
      wstrb <= sb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge aclk);
         if (!a_ok && awready) begin
            a_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [5:0] ix, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {ix, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task attk(input int n, input logic [3:0] b, input logic [1:0] s);
      repeat (n) rdr_u.pulse_att(smcp_att_t'({b, s}));
      #1;
   endtask
   task budget(input smcp_cls_t k, input int b);
      rdr_u.pulse_txn(k, 1'b1, 1'b0);
      repeat (b) @(posedge aclk);
      #1 chk(irq, 0, "early overrun");
      @(posedge aclk);
      #1 chk(irq, 1, "overrun missing");
      rdr_u.pulse_txn(k, 1'b0, 1'b1);
      wr(6'h05, 32'h8, 4'hF, rs);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         $display("MISMATCH t=%0t bench timeout", $time);
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'hA545;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         rd(6'(i), v, rs);
         chk(v, 0, "reset value");
      end
      wr(6'h0E, 32'hFFFF, 4'hF, rs);
      rd(6'h0E, v, rs);
      chk(v, 32'h1, "revision");
      rd(6'h0A, v, rs);
      chk({v[29:0], rs}, 32'h2, "unmapped read");
      wr(6'h0B, 32'h1, 4'hF, rs);
      chk(rs, 2'h2, "unmapped write");
      wr(6'h00, 32'hFF, 4'h0, rs);
      rd(6'h00, v, rs);
      chk(v, 0, "strobe off");
      $display("test registers done");
      // raise, clear and mask the nack interrupt
      wr(6'h06, 32'h1, 4'hF, rs);
      c = '0;
      c.valid = 1'b1;
      c.op = OP_SYS_WR;
      c.anti_tear = 1'b1;
      rdr_u.send_cmd(c, 0);
      #1 chk(32'(verd), {19'h0, 13'h1589}, "tear nack");
      @(posedge aclk);
      #1 chk(irq, 1, "irq raise");
      wr(6'h05, 32'h1, 4'hF, rs);
      rd(6'h05, v, rs);
      chk({v[30:0], irq}, 0, "irq clear");
      wr(6'h06, 32'h0, 4'hF, rs);
      rdr_u.send_cmd(c, 1);
      repeat (2) @(posedge aclk);
      #1 chk(irq, 0, "irq masked");
      $display("test interrupt done");
      // extended trials bit set yet limit stays fifteen
      wr(6'h04, 32'h2, 4'hF, rs);
      attk(14, 4'h8, 2'h0);
      rd(6'h08, v, rs);
      chk({v[3:0], pw_locked}, 8'hE0, "fourteen fails");
      attk(1, 4'h4, 2'h0);
      rd(6'h08, v, rs);
      chk(v[3:0], 0, "ok clears");
      attk(15, 4'h8, 2'h0);
      chk(pw_locked, 4'h1, "pw lock");
      attk(1, 4'h4, 2'h0);
      attk(15, 4'h2, 2'h3);
      chk(au_locked, 4'h8, "auth lock");
      rd(6'h08, v, rs);
      chk(v[3:0], 4'hF, "lock holds count");
      rd(6'h05, v, rs);
      chk(v[3:0], 4'h7, "lock events");
      wr(6'h05, 32'h7, 4'hF, rs);
      $display("test attempts done");
      for (int i = 0; i < 160; i++) begin
         if (i % 40 == 0) begin
            for (int z = 0; z < 4; z++) begin
               v = xs();
               ar[z] = v[7:0];
               wr(6'(z), v, 4'hF, rs);
               rd(6'(z), v, rs);
               chk(v, 32'(ar[z]), "zone access readback");
            end
            v = xs();
            wr(6'h04, {30'h0, v[1:0]}, 4'hF, rs); // random config bits
         end
         v = xs();
         c = v[17:0];
         c.valid = 1'b1;
         if (c.op > OP_SYS_RD) c.op = OP_USR_WR;
         if (v[20]) c.addr = pick[v[23:21]];
         rdr_u.send_cmd(c, int'(v[25:24]));
         #1 chk(32'(verd), 32'(exp_v(c)), "verdict");
         rd(6'h07, v, rs);
         chk(v, (32'(exp_v(c)) >> 3) & 32'hFF, "last status");
      end
      chk({pw_locked, au_locked}, 8'h18, "state kept");
      $display("test policy done");
      wr(6'h05, 32'h1, 4'hF, rs);
      wr(6'h06, 32'h8, 4'hF, rs);
      budget(CLS_AT8, 40);
      budget(CLS_W16, 30);
      budget(CLS_R64, 35);
      rdr_u.pulse_txn(CLS_W16, 1'b1, 1'b0);
      repeat (9) @(posedge aclk);
      rdr_u.pulse_txn(CLS_W16, 1'b0, 1'b1);
      rd(6'h09, v, rs);
      chk(v, 32'hA, "timer value");
      rdr_u.pulse_txn(CLS_NONE, 1'b1, 1'b0);
      repeat (60) @(posedge aclk);
      #1 chk(irq, 0, "no budget");
      $display("test timing done");
      // locks leave only through reset
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1 chk({pw_locked, au_locked, irq}, 0, "reset clears locks");
      $display("test reset done");
      summarize();
   end
endmodule // smcp_policy_tb

// file: dv/smcp_reader_model.sv
/*
 Reader-side model: drives parsed commands, attempt pulses and transaction
 brackets into the policy block. Assumes the bench calls its tasks and
 supplies aclk.
*/
`timescale 1ns/10ps
module smcp_reader_model (
   input wire logic aclk,
   output smcp_pkg::smcp_cmd_t cmd,
   output smcp_pkg::smcp_att_t att,
   output smcp_pkg::smcp_txn_t txn
);
   import smcp_pkg::*;
   initial begin
      cmd = '0;
      att = '0;
      txn = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // reader states checksum result
   task automatic send_cmd(input smcp_cmd_t c, input int gap);
      smcp_cmd_t junk;
      junk = ~c;
      junk.valid = 1'b0;
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      cmd <= c;
      @(posedge aclk);
      // idle fields never repeat the last command
      cmd <= junk;
   endtask
   task automatic pulse_att(input smcp_att_t a);
      @(posedge aclk);
      att <= a;
      @(posedge aclk);
      att <= '0;
   endtask
   task automatic pulse_txn(input smcp_cls_t k, input logic s, input logic d);
      @(posedge aclk);
      txn <= '{start: s, done: d, cls: k};
      @(posedge aclk);
      txn <= '0;
   endtask
endmodule // smcp_reader_model

// file: hw/smcp_pkg.sv
/*
 Types of the command policy block.
 Assumes smcp_regs.svh for the numbers.
*/
package smcp_pkg;
   localparam int SMCP_TMR_W = 24;
   typedef enum logic [2:0] {
      OP_OTHER = 3'h0, OP_USR_WR = 3'h1, OP_USR_RD = 3'h2, OP_SYS_WR = 3'h3, OP_SYS_RD = 3'h4
   } smcp_op_t;
   typedef enum logic [1:0] {CLS_NONE = 2'h0, CLS_R64 = 2'h1, CLS_W16 = 2'h2, CLS_AT8 = 2'h3}
      smcp_cls_t;
   typedef enum logic [1:0] {MD_OPEN = 2'h0, MD_AUTH = 2'h1, MD_ENC = 2'h2, MD_ENC_ALT = 2'h3}
      smcp_mode_t;
   typedef struct packed {
      logic valid;
      smcp_op_t op;
      logic [1:0] zone;
      logic [7:0] addr;
      logic anti_tear;
      logic auth_on;
      logic enc_on;
      logic cksum_ok;
   } smcp_cmd_t;
   typedef struct packed {
      logic valid;
      logic ack;
      logic [7:0] status;
      logic wr_en;
      logic prog_only;
      logic otp;
   } smcp_verd_t;
   typedef struct packed {
      logic pw_fail;
      logic pw_ok;
      logic au_fail;
      logic au_ok;
      logic [1:0] set;
   } smcp_att_t;
   typedef struct packed {
      logic start;
      logic done;
      smcp_cls_t cls;
   } smcp_txn_t;
endpackage

// file: hw/smcp_policy.sv
/*
 Command acceptance and security policy checker with AXI4-Lite registers.
 Assumes the command decoder presents one parsed command per cmd.valid
 pulse and that attempt and transaction events are one-cycle pulses.
*/
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "smcp_regs.svh"

// What this block does
// - NACK status names first detected error only
// - program-only honoured only in zone one
// - write-lock bit is ignored
// - unlimited checksum bit is ignored
// - fifteen failures lock; extended trials ignored
// - old dual-access code selects encryption mode
// - secure-mode writes need valid checksum
// - system write with anti-tearing is NACKed
// - writes to reserved configuration bytes NACKed
// - reads starting on reserved byte NACKed
// - twenty-five configuration bytes are OTP
// - bytes 0E and 0F are hardware revision
// - transaction time runs start to response end
// - anti-tearing 8-byte write within 11.0 ms
// - 16-byte write within 6.1 ms
// - 64-byte read within 9.2 ms
module smcp_policy #(
   parameter logic [15:0] HW_REV = 16'h0001, // arbitrary value
   parameter int unsigned AT8_MAX_CYC = `SMCP_T_AT8_MAX_US * `SMCP_CLK_MHZ,
   parameter int unsigned W16_MAX_CYC = `SMCP_T_W16_MAX_US * `SMCP_CLK_MHZ,
   parameter int unsigned R64_MAX_CYC = `SMCP_T_R64_MAX_US * `SMCP_CLK_MHZ
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire smcp_pkg::smcp_cmd_t cmd,
   output smcp_pkg::smcp_verd_t verd,
   input wire smcp_pkg::smcp_att_t att,
   output logic [3:0] pw_locked,
   output logic [3:0] au_locked,
   input wire smcp_pkg::smcp_txn_t txn,
   output logic irq
);
   import smcp_pkg::*;

   typedef struct packed {
      logic aw_have;
      logic [5:0] aw_idx;
      logic w_have;
      logic [7:0] wbyte;
      logic wlane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [3:0][7:0] ar;
      logic [7:0] device_config_register;
      logic [3:0] isr;
      logic [3:0] imr;
      logic irq;
      smcp_verd_t verd;
      logic [7:0] last_st;
      logic [3:0][3:0] pw_cnt;
      logic [3:0][3:0] au_cnt;
      logic [3:0] pw_lk;
      logic [3:0] au_lk;
      logic tmr_run;
      logic tmr_arm;
      logic [SMCP_TMR_W-1:0] tmr;
      logic [SMCP_TMR_W-1:0] budget;
      logic [SMCP_TMR_W-1:0] tmr_last;
   } smcp_state_t;

   smcp_state_t s_q;
   smcp_state_t s_d;

   ////////////////////////////////////////////////////////////////////////
   // configuration memory map

   function automatic logic cfg_rsv(input logic [7:0] a);
      return (a >= `SMCP_RSV_LO) && (a <= `SMCP_RSV_HI);
   endfunction

   function automatic logic cfg_hwr(input logic [7:0] a);
      return (a >= `SMCP_HWR_LO) && (a <= `SMCP_HWR_HI);
   endfunction

   function automatic logic cfg_otp(input logic [7:0] a);
      return (a <= `SMCP_OTP_A_HI) || ((a >= `SMCP_OTP_B_LO) && (a <= `SMCP_OTP_B_HI));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // attempt counters, one per key or password set

   logic [3:0][3:0] pw_cnt_n;
   logic [3:0][3:0] au_cnt_n;
   logic [3:0] pw_lk_ev;
   logic [3:0] au_lk_ev;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_att
         logic hit;
         assign hit = (att.set == 2'(i));
         // fixed limit of fifteen; fail wins over ok
         assign pw_cnt_n[i] = (!hit || s_q.pw_lk[i]) ? s_q.pw_cnt[i]
                              : att.pw_fail ? s_q.pw_cnt[i] + 4'h1
                              : att.pw_ok ? 4'h0 : s_q.pw_cnt[i];
         assign au_cnt_n[i] = (!hit || s_q.au_lk[i]) ? s_q.au_cnt[i]
                              : att.au_fail ? s_q.au_cnt[i] + 4'h1
                              : att.au_ok ? 4'h0 : s_q.au_cnt[i];
         assign pw_lk_ev[i] = !s_q.pw_lk[i] && (pw_cnt_n[i] == `SMCP_ATT_LIMIT);
         assign au_lk_ev[i] = !s_q.au_lk[i] && (au_cnt_n[i] == `SMCP_ATT_LIMIT);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // command check

   logic [7:0] sel_ar;
   smcp_mode_t mode;
   logic is_wr;
   logic [7:0] st;
   logic program_only_bit;

   always_comb begin
      sel_ar = s_q.ar[cmd.zone];
      mode = smcp_mode_t'(sel_ar[`SMCP_AR_MODE_HI:`SMCP_AR_MODE_LO]);
      is_wr = (cmd.op == OP_USR_WR) || (cmd.op == OP_SYS_WR);
      program_only_bit = sel_ar[`SMCP_AR_PGO] && (cmd.zone == `SMCP_PGO_ZONE);
      // fixed check order, first hit wins
      if (cmd.op == OP_SYS_WR && cmd.anti_tear) begin
         st = `SMCP_ST_AT;
      end else if (cmd.op == OP_SYS_WR && cfg_rsv(cmd.addr)) begin
         st = `SMCP_ST_RSV;
      end else if (cmd.op == OP_SYS_WR && cfg_hwr(cmd.addr)) begin
         st = `SMCP_ST_RO;
      end else if (cmd.op == OP_SYS_RD && cfg_rsv(cmd.addr)) begin
         st = `SMCP_ST_RSV;
      end else if (is_wr && (cmd.auth_on || cmd.enc_on) && !cmd.cksum_ok) begin
         st = `SMCP_ST_CKSUM;
      end else if (cmd.op == OP_USR_WR && mode == MD_AUTH && !(cmd.auth_on || cmd.enc_on)) begin
         st = `SMCP_ST_ACC;
      end else if (cmd.op == OP_USR_WR && (mode == MD_ENC || mode == MD_ENC_ALT) && !cmd.enc_on)
      begin
         st = `SMCP_ST_ACC;
      end else begin
         st = `SMCP_ST_OK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   logic [5:0] ar_idx;
   logic [3:0] ev;
   logic [SMCP_TMR_W-1:0] bud;

   always_comb begin
      s_d = s_q;
      ar_idx = araddr[7:2];
      ev = 4'h0;
      // rejected commands raise no write strobe
      s_d.verd.valid = cmd.valid;
      s_d.verd.ack = cmd.valid && (st == `SMCP_ST_OK);
      s_d.verd.status = cmd.valid ? st : `SMCP_ST_OK;
      s_d.verd.wr_en = cmd.valid && is_wr && (st == `SMCP_ST_OK);
      s_d.verd.prog_only = cmd.valid && (cmd.op == OP_USR_WR) && program_only_bit;
      s_d.verd.otp = cmd.valid && (cmd.op == OP_SYS_WR) && cfg_otp(cmd.addr);
      if (cmd.valid) begin
         s_d.last_st = st;
      end
      ev[`SMCP_EV_NACK] = cmd.valid && (st != `SMCP_ST_OK);
      s_d.pw_cnt = pw_cnt_n;
      s_d.au_cnt = au_cnt_n;
      s_d.pw_lk = s_q.pw_lk | pw_lk_ev;
      s_d.au_lk = s_q.au_lk | au_lk_ev;
      ev[`SMCP_EV_PWLK] = |pw_lk_ev;
      ev[`SMCP_EV_AULK] = |au_lk_ev;
      unique case (txn.cls)
         CLS_AT8: bud = SMCP_TMR_W'(AT8_MAX_CYC);
         CLS_W16: bud = SMCP_TMR_W'(W16_MAX_CYC);
         CLS_R64: bud = SMCP_TMR_W'(R64_MAX_CYC);
         CLS_NONE: bud = '0;
      endcase
      // timed from command start to response end
      if (txn.start) begin
         s_d.tmr_run = 1'b1;
         s_d.tmr_arm = (txn.cls != CLS_NONE);
         s_d.tmr = '0;
         s_d.budget = bud;
      end else if (s_q.tmr_run) begin
         if (s_q.tmr != '1) begin
            s_d.tmr = s_q.tmr + 1'b1;
         end
         if (s_q.tmr_arm && s_q.tmr == s_q.budget) begin
            ev[`SMCP_EV_OVR] = 1'b1;
            s_d.tmr_arm = 1'b0;
         end
         if (txn.done) begin
            s_d.tmr_run = 1'b0;
            s_d.tmr_arm = 1'b0;
            s_d.tmr_last = s_q.tmr;
         end
      end
      // write channel: address and data in either order
      if (awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_idx = awaddr[7:2];
      end
      if (wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wbyte = wdata[7:0];
         s_d.wlane = wstrb[0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = 2'h0;
         if (s_q.aw_idx <= `SMCP_IDX_AR3) begin
            if (s_q.wlane) begin
               s_d.ar[s_q.aw_idx[1:0]] = s_q.wbyte;
            end
         end else if (s_q.aw_idx == `SMCP_IDX_DCR) begin
            // unlimited checksum bit stored, never used
            if (s_q.wlane) begin
               s_d.device_config_register = s_q.wbyte;
            end
         end else if (s_q.aw_idx == `SMCP_IDX_ISR) begin
            if (s_q.wlane) begin
               s_d.isr = s_q.isr & ~s_q.wbyte[3:0];
            end
         end else if (s_q.aw_idx == `SMCP_IDX_IMR) begin
            if (s_q.wlane) begin
               s_d.imr = s_q.wbyte[3:0];
            end
         end else if (!(s_q.aw_idx inside {`SMCP_IDX_LAST, `SMCP_IDX_CNT, `SMCP_IDX_TMR,
                                           `SMCP_IDX_HWR})) begin
            s_d.bresp = 2'h2;
         end
      end
      // set beats clear
      s_d.isr = s_d.isr | ev;
      s_d.irq = |(s_d.isr & s_d.imr);
      // read channel
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = 2'h0;
         s_d.rdata = '0;
         if (ar_idx <= `SMCP_IDX_AR3) begin
            s_d.rdata[7:0] = s_q.ar[ar_idx[1:0]];
         end else if (ar_idx == `SMCP_IDX_DCR) begin
            s_d.rdata[7:0] = s_q.device_config_register;
         end else if (ar_idx == `SMCP_IDX_ISR) begin
            s_d.rdata[3:0] = s_q.isr;
         end else if (ar_idx == `SMCP_IDX_IMR) begin
            s_d.rdata[3:0] = s_q.imr;
         end else if (ar_idx == `SMCP_IDX_LAST) begin
            s_d.rdata[7:0] = s_q.last_st;
         end else if (ar_idx == `SMCP_IDX_CNT) begin
            s_d.rdata = {s_q.au_cnt, s_q.pw_cnt};
         end else if (ar_idx == `SMCP_IDX_TMR) begin
            s_d.rdata[SMCP_TMR_W-1:0] = s_q.tmr_last;
         end else if (ar_idx == `SMCP_IDX_HWR) begin
            s_d.rdata[15:0] = HW_REV;
         end else begin
            s_d.rresp = 2'h2;
         end
      end
      // readiness taken from the next state so ports stay registered
      s_d.awready = !s_d.aw_have;
      s_d.wready = !s_d.w_have;
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.ar <= {4{`SMCP_AR_RST}};
         s_q.device_config_register <= `SMCP_DCR_RST;
         s_q.imr <= `SMCP_IMR_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rresp = s_q.rresp;
   assign rdata = s_q.rdata;
   assign verd = s_q.verd;
   assign pw_locked = s_q.pw_lk;
   assign au_locked = s_q.au_lk;
   assign irq = s_q.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_first_err_wins: assert property (
      cmd.valid && cmd.op == OP_SYS_WR && cmd.anti_tear && cfg_rsv(cmd.addr)
      |=> verd.status == `SMCP_ST_AT)
      else $error("later error reported before anti-tearing error");
   a_pgo_zone_one: assert property (
      verd.prog_only |-> $past(cmd.zone) == `SMCP_PGO_ZONE)
      else $error("program-only outside zone one");
   a_wlock_ignored: assert property (
      cmd.valid && cmd.op == OP_USR_WR && !cmd.auth_on && !cmd.enc_on
      && s_q.ar[cmd.zone][`SMCP_AR_MODE_HI:`SMCP_AR_MODE_LO] == 2'h0 |=> verd.ack && verd.wr_en)
      else $error("open zone write refused");
   a_lock_at_limit: assert property (
      att.pw_fail && !pw_locked[att.set] && s_q.pw_cnt[att.set] == 4'hE
      |=> pw_locked[$past(att.set)] && (irq || !$past(s_q.imr[`SMCP_EV_PWLK]))
      ##1 pw_locked[$past(att.set, 2)])
      else $error("password not locked after fifteenth failure");
   a_cksum_gate: assert property (
      cmd.valid && (cmd.op == OP_USR_WR || cmd.op == OP_SYS_WR)
      && (cmd.auth_on || cmd.enc_on) && !cmd.cksum_ok |=> !verd.ack && !verd.wr_en)
      else $error("secure write without checksum accepted");
   a_at_sys_nack: assert property (
      cmd.valid && cmd.op == OP_SYS_WR && cmd.anti_tear |=> verd.valid && !verd.ack)
      else $error("anti-tearing system write accepted");
   a_rsv_write: assert property (
      cmd.valid && cmd.op == OP_SYS_WR && cfg_rsv(cmd.addr) |=> !verd.wr_en && !verd.ack)
      else $error("reserved byte write accepted");
   a_rsv_read: assert property (
      cmd.valid && cmd.op == OP_SYS_RD && cfg_rsv(cmd.addr) |=> !verd.ack)
      else $error("reserved start read accepted");
   a_hwr_ro: assert property (
      cmd.valid && cmd.op == OP_SYS_WR && cfg_hwr(cmd.addr) |=> !verd.wr_en)
      else $error("hardware revision byte written");
   a_budget_ovr: assert property (
      s_q.tmr_run && s_q.tmr_arm && s_q.tmr == s_q.budget && !txn.start
      |=> s_q.isr[`SMCP_EV_OVR])
      else $error("budget overrun not flagged");
   a_nack_no_wr: assert property (
      verd.valid && !verd.ack
      |-> !verd.wr_en && ($stable(s_q.ar) || $past(s_q.aw_have && s_q.w_have)))
      else $error("write strobe on a rejected command");

   c_nack_seen: cover property (verd.valid && !verd.ack);
   c_pw_lock: cover property ($rose(pw_locked[0]));
   c_ovr_irq: cover property (s_q.isr[`SMCP_EV_OVR] && irq);
endmodule // smcp_policy

// file: hw/smcp_regs.svh
/*
 Offsets, field positions, reset values, status codes and time budgets
 of the command policy block. Assumes a 200 MHz aclk.
*/
`ifndef SMCP_REGS_SVH
`define SMCP_REGS_SVH
// register index; byte address is four times the index
`define SMCP_IDX_AR0 6'h00
`define SMCP_IDX_AR3 6'h03
`define SMCP_IDX_DCR 6'h04
`define SMCP_IDX_ISR 6'h05
`define SMCP_IDX_IMR 6'h06
`define SMCP_IDX_LAST 6'h07
`define SMCP_IDX_CNT 6'h08
`define SMCP_IDX_TMR 6'h09
`define SMCP_IDX_HWR 6'h0E
// zone access register fields
`define SMCP_AR_PGO 0
`define SMCP_AR_WLOCK 1
`define SMCP_AR_MODE_LO 2
`define SMCP_AR_MODE_HI 3
`define SMCP_AR_RST 8'h00
// device config register fields
`define SMCP_DCR_UNLCK 0
`define SMCP_DCR_ETRIAL 1
`define SMCP_DCR_RST 8'h00
// interrupt bits, program-only zone and attempt limit
`define SMCP_EV_NACK 0
`define SMCP_EV_PWLK 1
`define SMCP_EV_AULK 2
`define SMCP_EV_OVR 3
`define SMCP_IMR_RST 4'h0
`define SMCP_PGO_ZONE 2'h1
`define SMCP_ATT_LIMIT 4'hF
// configuration memory map
`define SMCP_HWR_LO 8'h0E
`define SMCP_HWR_HI 8'h0F
`define SMCP_OTP_A_LO 8'h00
`define SMCP_OTP_A_HI 8'h0D
`define SMCP_OTP_B_LO 8'h18
`define SMCP_OTP_B_HI 8'h22
`define SMCP_RSV_LO 8'hC0
`define SMCP_RSV_HI 8'hFF
// status codes
`define SMCP_ST_OK 8'h00
`define SMCP_ST_AT 8'hB1
`define SMCP_ST_RSV 8'hB2
`define SMCP_ST_RO 8'hB3
`define SMCP_ST_CKSUM 8'hB4
`define SMCP_ST_ACC 8'hB5
// time budgets in microseconds, clock in MHz
`define SMCP_CLK_MHZ 200
`define SMCP_T_AT8_MAX_US 11000
`define SMCP_T_W16_MAX_US 6100
`define SMCP_T_R64_MAX_US 9200
`endif
